/* File: src/prot_params.svh */
`ifndef PROT_PARAMS_SVH
`define PROT_PARAMS_SVH

// Register word indices on the plain register port
`define REG_CTRL 4'h0
`define REG_PICKUP 4'h1
`define REG_DELAY 4'h2
`define REG_IEC_K 4'h3
`define REG_IEEE_K 4'h4
`define REG_STATUS 4'h5
`define REG_EVT_COUNT 4'h6
`define REG_EVT_MAG 4'h7

// Control register fields
`define CTRL_DELAY_TYPE 0
`define CTRL_SERIES 1
`define CTRL_TEST_MODE 2
`define CTRL_TEST_BLOCK 3
`define CTRL_UNDER 4

// Delay type and curve series codes
`define DELAY_DEFINITE 1'h0
`define DELAY_INVERSE 1'h1
`define SERIES_IEC 1'h0
`define SERIES_IEEE 1'h1

// Reset values
`define CTRL_RESET 5'h00
`define PICKUP_RESET 16'h0100
`define DELAY_RESET 19'h00008
`define IEC_K_RESET 16'h0064
`define IEEE_K_RESET 16'h0032

// Reset ratio in percent
`define RESET_RATIO_PCT 7'h61
`define PCT_FULL 7'h64

// Program cycle and delay step: 5 ms, clock 50 ns
`define CLOCK_PERIOD_NS 50
`define PROGRAM_CYCLE_NS 5000000
`define PROGRAM_CYCLE_CLOCKS (`PROGRAM_CYCLE_NS / `CLOCK_PERIOD_NS)

`endif

/* File: src/prot_pkg.sv */
`default_nettype none

package prot_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_BLOCKED = 4'h4,
    ST_TRIP = 4'h8
  } stage_state_t;

  typedef struct packed {
    logic under_mode;
    logic test_block;
    logic test_mode;
    logic series;
    logic delay_type;
  } ctrl_t;

  typedef struct packed {
    logic [31:0] timestamp;
    logic [15:0] magnitude;
    logic [2:0] fault_type;
  } block_event_t;

  typedef struct packed {
    logic pickup;
    logic start;
    logic trip;
    logic blocked;
  } stage_flags_t;

endpackage : prot_pkg

`default_nettype wire

/* File: src/protection_pickup_trip_timer.sv */
`include "prot_params.svh"
`default_nettype none

module protection_pickup_trip_timer #(
  parameter int CYCLE_CLOCKS = `PROGRAM_CYCLE_CLOCKS,
  parameter int MAG_W = 16,
  parameter int DELAY_W = 19
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] read_data,
  input wire logic [MAG_W-1:0] measured_magnitude,
  input wire logic [2:0] fault_type,
  input wire logic blocking_in,
  output logic start,
  output logic trip,
  output logic blocked,
  output logic pickup,
  output logic display_event,
  output logic block_event_valid,
  output prot_pkg::block_event_t block_event
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Level scaled by percent, floor of the product
  function automatic logic [MAG_W-1:0] scale_pct(
    input logic [MAG_W-1:0] level,
    input logic [6:0] pct
  );
    logic [MAG_W+6:0] prod;
    prod = level * pct;
    scale_pct = MAG_W'(prod / `PCT_FULL);
  endfunction : scale_pct

  ////////////////////////////////////////////////////////////////////////////
  // Settings

  prot_pkg::ctrl_t ctrl;
  logic [MAG_W-1:0] pickup_level;
  logic [DELAY_W-1:0] definite_delay;
  logic [MAG_W-1:0] iec_k;
  logic [MAG_W-1:0] ieee_k;
  logic [15:0] event_count;
  logic [MAG_W-1:0] event_mag;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl <= prot_pkg::ctrl_t'(`CTRL_RESET);
      pickup_level <= MAG_W'(`PICKUP_RESET);
      definite_delay <= DELAY_W'(`DELAY_RESET);
      iec_k <= MAG_W'(`IEC_K_RESET);
      ieee_k <= MAG_W'(`IEEE_K_RESET);
    end
    else if (write_strobe)
    begin
      unique case (address)
        `REG_CTRL: ctrl <= prot_pkg::ctrl_t'(write_data[4:0]);
        `REG_PICKUP: pickup_level <= write_data[MAG_W-1:0];
        `REG_DELAY: definite_delay <= write_data[DELAY_W-1:0];
        `REG_IEC_K: iec_k <= write_data[MAG_W-1:0];
        `REG_IEEE_K: ieee_k <= write_data[MAG_W-1:0];
        default: ;
      endcase
    end
  end

  logic [31:0] next_read_data;

  always_comb
  begin
    next_read_data = 32'h0;
    unique case (address)
      `REG_CTRL: next_read_data = {27'h0, ctrl};
      `REG_PICKUP: next_read_data = 32'(pickup_level);
      `REG_DELAY: next_read_data = 32'(definite_delay);
      `REG_IEC_K: next_read_data = 32'(iec_k);
      `REG_IEEE_K: next_read_data = 32'(ieee_k);
      `REG_STATUS: next_read_data = {28'h0, pickup, start, trip, blocked};
      `REG_EVT_COUNT: next_read_data = {16'h0, event_count};
      `REG_EVT_MAG: next_read_data = 32'(event_mag);
      default: next_read_data = 32'h0;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clock)
  begin
    if (rst)
      read_data <= 32'h0;
    else if (read_strobe)
      read_data <= next_read_data;
    else
      read_data <= 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program cycle tick and timestamp

  logic [31:0] cycle_div;
  logic tick;
  logic [31:0] timestamp;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cycle_div <= 32'h0;
      tick <= 1'b0;
    end
    else if (cycle_div == 32'(CYCLE_CLOCKS - 1))
    begin
      cycle_div <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cycle_div <= cycle_div + 32'h1;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      timestamp <= 32'h0;
    else if (tick)
      timestamp <= timestamp + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling at the start of each program cycle

  logic block_sample;
  logic [MAG_W-1:0] mag_sample;

  // A block landing later than one program cycle before expiry may miss
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      block_sample <= 1'b0;
      mag_sample <= '0;
    end
    else if (tick)
    begin
      block_sample <= blocking_in | (ctrl.test_mode & ctrl.test_block);
      mag_sample <= measured_magnitude;
    end
  end

  // Evaluated one clock after the tick, on settled samples
  logic eval;

  always_ff @(posedge clock)
  begin
    if (rst)
      eval <= 1'b0;
    else
      eval <= tick;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pick-up with hysteresis

  logic [MAG_W-1:0] release_over;
  logic [MAG_W:0] release_under;
  logic next_pickup;

  always_comb
  begin
    release_over = scale_pct(pickup_level, `RESET_RATIO_PCT);
    release_under = {1'b0, pickup_level} + {1'b0, pickup_level - release_over};
    next_pickup = pickup;
    if (!ctrl.under_mode)
    begin
      if (mag_sample > pickup_level)
        next_pickup = 1'b1;
      else if (mag_sample < release_over)
        next_pickup = 1'b0;
    end
    else
    begin
      if (mag_sample < pickup_level)
        next_pickup = 1'b1;
      else if ({1'b0, mag_sample} > release_under)
        next_pickup = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      pickup <= 1'b0;
    else if (eval)
      pickup <= next_pickup;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating timers

  prot_pkg::stage_state_t state;
  prot_pkg::stage_state_t next_state;
  logic [DELAY_W-1:0] op_timer;
  logic [47:0] inverse_acc;
  logic [31:0] inverse_limit;
  logic min_done;
  logic delay_done;
  logic instant;
  logic timing;

  assign timing = pickup & next_pickup & (state == prot_pkg::ST_START) & ~block_sample;
  assign instant = (definite_delay == '0) & (ctrl.delay_type == `DELAY_DEFINITE);

  // Series choice only steers the inverse limit
  always_comb
  begin
    inverse_limit = pickup_level * ((ctrl.series == `SERIES_IEEE) ? ieee_k : iec_k);
    min_done = (32'(op_timer) + 32'h1) >= 32'(definite_delay);
    if (ctrl.delay_type == `DELAY_DEFINITE)
      delay_done = min_done;
    else
      delay_done = min_done & ((inverse_acc + 48'(mag_sample)) >= 48'(inverse_limit));
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      op_timer <= '0;
      inverse_acc <= 48'h0;
    end
    else if (eval)
    begin
      if (timing)
      begin
        if (op_timer != '1)
          op_timer <= op_timer + DELAY_W'(1);
        if (!inverse_acc[47])
          inverse_acc <= inverse_acc + 48'(mag_sample);
      end
      else if (state != prot_pkg::ST_TRIP)
      begin
        op_timer <= '0;
        inverse_acc <= 48'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage sequence

  logic raise_block;

  always_comb
  begin
    next_state = state;
    raise_block = 1'b0;
    unique case (state)
      prot_pkg::ST_IDLE:
      begin
        if (next_pickup && block_sample)
        begin
          next_state = prot_pkg::ST_BLOCKED;
          raise_block = 1'b1;
        end
        else if (next_pickup && instant)
          next_state = prot_pkg::ST_TRIP;
        else if (next_pickup)
          next_state = prot_pkg::ST_START;
      end
      prot_pkg::ST_START:
      begin
        if (block_sample)
        begin
          next_state = prot_pkg::ST_IDLE;
          raise_block = 1'b1;
        end
        else if (!next_pickup)
          next_state = prot_pkg::ST_IDLE;
        else if (delay_done)
          next_state = prot_pkg::ST_TRIP;
      end
      prot_pkg::ST_BLOCKED:
      begin
        if (!next_pickup)
          next_state = prot_pkg::ST_IDLE;
      end
      prot_pkg::ST_TRIP:
      begin
        if (!next_pickup)
          next_state = prot_pkg::ST_IDLE;
      end
      default: next_state = prot_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state <= prot_pkg::ST_IDLE;
    else if (eval)
      state <= next_state;
  end

  // Start stays up through trip; both drop with the pick-up
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      start <= 1'b0;
      trip <= 1'b0;
      blocked <= 1'b0;
    end
    else if (eval)
    begin
      start <= (next_state == prot_pkg::ST_START) | (next_state == prot_pkg::ST_TRIP);
      trip <= next_state == prot_pkg::ST_TRIP;
      blocked <= next_state == prot_pkg::ST_BLOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blocking events

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      display_event <= 1'b0;
      block_event_valid <= 1'b0;
      block_event <= '0;
    end
    else
    begin
      display_event <= eval & raise_block;
      block_event_valid <= eval & raise_block;
      if (eval && raise_block)
        block_event <= '{timestamp: timestamp, magnitude: 16'(mag_sample),
          fault_type: fault_type};
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      event_count <= 16'h0;
      event_mag <= '0;
    end
    else if (eval && raise_block)
    begin
      event_count <= event_count + 16'h1;
      event_mag <= mag_sample;
    end
  end

endmodule : protection_pickup_trip_timer

`default_nettype wire

/* File: tb/trip_timer_monitor.sv */
`default_nettype none

module trip_timer_monitor #(
  parameter int CYCLE_CLOCKS = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic read_strobe,
  input wire logic [31:0] read_data,
  input wire logic start,
  input wire logic trip,
  input wire logic blocked,
  input wire logic pickup,
  input wire logic display_event,
  input wire logic block_event_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  start_not_blocked_a: assert property (!(start && blocked))
    else $error("start and blocked together");
  start_has_pickup_a: assert property (start |-> pickup)
    else $error("start without pickup");
  blocked_has_pickup_a: assert property (blocked |-> pickup)
    else $error("blocked without pickup");
  trip_has_start_a: assert property (trip |-> start)
    else $error("trip without start");
  event_pair_a: assert property (display_event == block_event_valid)
    else $error("event pulses differ");
  event_pulse_a: assert property (display_event |=> !display_event)
    else $error("event longer than one clock");
  event_no_start_a: assert property (display_event |-> !start)
    else $error("start kept on blocking");
  start_per_cycle_a: assert property ($rose(start) |=> $stable(start)[*3])
    else $error("start changed inside a program cycle");
  read_idle_a: assert property (!$past(read_strobe) |-> read_data == 32'h0)
    else $error("read data outside read cycle");

endmodule : trip_timer_monitor

`default_nettype wire

/* File: tb/meas_source.sv */
`default_nettype none

// Measurement path and blocking matrix; levels change only after an edge
module meas_source (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] set_mag,
  input wire logic set_block,
  input wire logic [2:0] set_fault,
  output logic [15:0] measured_magnitude,
  output logic blocking_in,
  output logic [2:0] fault_type
);
  timeunit 1ns;
  timeprecision 1ns;

  always_ff @(posedge clock)
  begin
    measured_magnitude <= rst ? 16'h0 : set_mag;
    fault_type <= rst ? 3'h0 : set_fault;
  end

  // Blocking held as a level, raised cycles ahead of any delay end
  always_ff @(posedge clock)
    blocking_in <= rst ? 1'b0 : set_block;

endmodule : meas_source

`default_nettype wire

/* File: tb/protection_pickup_trip_timer_tb_top.sv */
`default_nettype none

module protection_pickup_trip_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic [31:0] write_data = 32'h0;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [15:0] want_mag = 16'h0;
  logic want_block = 1'b0;
  logic [2:0] want_fault = 3'h5;
  logic [31:0] read_data;
  logic [15:0] measured_magnitude;
  logic [2:0] fault_type;
  logic blocking_in;
  logic start;
  logic trip;
  logic blocked;
  logic pickup;
  logic display_event;
  logic block_event_valid;
  prot_pkg::block_event_t block_event;
  prot_pkg::block_event_t last_ev;
  int fails = 0;
  int compares = 0;
  int n1;
  int n2;

  initial forever #25 clock = ~clock;

  protection_pickup_trip_timer #(.CYCLE_CLOCKS(4)) i_protection_pickup_trip_timer (
    .clock(clock), .rst(rst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .measured_magnitude(measured_magnitude), .fault_type(fault_type),
    .blocking_in(blocking_in), .start(start), .trip(trip), .blocked(blocked),
    .pickup(pickup), .display_event(display_event),
    .block_event_valid(block_event_valid), .block_event(block_event));

  meas_source i_meas_source (
    .clock(clock), .rst(rst), .set_mag(want_mag), .set_block(want_block),
    .set_fault(want_fault), .measured_magnitude(measured_magnitude),
    .blocking_in(blocking_in), .fault_type(fault_type));

  // Sampled mid-cycle so the design's edge updates have landed
  always @(negedge clock)
    if (display_event === 1'b1)
      last_ev = block_event;

  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    chk("read_data", read_data, e);
  endtask : rd

  task pc(input int k);
    repeat (k * 4) @(negedge clock);
  endtask : pc

  task setm(input logic [15:0] m, input logic b);
    @(posedge clock);
    want_mag <= m;
    want_block <= b;
  endtask : setm

  // Clocks from start rising to trip rising
  task span(output int n);
    int k;
    k = 0;
    while (start !== 1'b1 && k < 400)
    begin
      @(negedge clock);
      k++;
    end
    n = 0;
    while (trip !== 1'b1 && n < 400)
    begin
      @(negedge clock);
      n++;
    end
  endtask : span

  task idle();
    setm(16'h0, 1'b0);
    pc(3);
    chk("outputs", {pickup, start, trip, blocked}, 4'h0);
  endtask : idle

  task report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////
  task t_regs();
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h100);
    rd(4'h2, 32'h8);
    rd(4'h3, 32'h64);
    rd(4'h4, 32'h32);
    wr(4'h5, 32'hf);
    rd(4'h5, 32'h0);
    rd(4'h8, 32'h0);
    $display("regs done");
  endtask : t_regs

  task t_definite();
    wr(4'h1, 32'h64);
    wr(4'h2, 32'h2);
    setm(16'h80, 1'b0);
    span(n1);
    chk("def_span", n1, 8);
    rd(4'h5, 32'he);
    setm(16'h61, 1'b0);
    pc(3);
    chk("pickup_hold", pickup, 1'b1);
    idle();
    $display("definite done");
  endtask : t_definite

  task t_instant();
    wr(4'h0, 32'h2);
    wr(4'h2, 32'h0);
    setm(16'h80, 1'b0);
    span(n1);
    chk("inst_span", n1, 0);
    chk("inst_trip", trip, 1'b1);
    idle();
    $display("instant done");
  endtask : t_instant

  task t_early();
    wr(4'h2, 32'h8);
    setm(16'h80, 1'b0);
    pc(3);
    chk("early_start", {start, trip}, 2'h2);
    idle();
    pc(10);
    chk("early_trip", trip, 1'b0);
    $display("early release done");
  endtask : t_early

  task t_block();
    setm(16'h80, 1'b1);
    pc(3);
    chk("blk_state", {start, blocked}, 2'h1);
    chk("evt_mag", last_ev.magnitude, 16'h80);
    chk("evt_fault", last_ev.fault_type, 3'h5);
    n1 = last_ev.timestamp;
    idle();
    setm(16'h80, 1'b0);
    pc(3);
    chk("late_start", start, 1'b1);
    setm(16'h80, 1'b1);
    pc(3);
    chk("late_blk", {start, trip}, 2'h0);
    idle();
    wr(4'h0, 32'hc);
    setm(16'h80, 1'b0);
    pc(3);
    chk("soft_blk", {start, blocked}, 2'h1);
    chk("evt_stamp", last_ev.timestamp > n1, 1'b1);
    rd(4'h7, 32'h80);
    wr(4'h0, 32'h0);
    idle();
    $display("blocking done");
  endtask : t_block

  task t_inverse();
    wr(4'h0, 32'h1);
    wr(4'h2, 32'h14);
    setm(16'h1000, 1'b0);
    span(n1);
    chk("inv_min", n1, 80);
    idle();
    wr(4'h2, 32'h0);
    setm(16'h800, 1'b0);
    span(n1);
    idle();
    setm(16'h2000, 1'b0);
    span(n2);
    // Stronger measurement must trip sooner
    chk("inv_order", n1 > n2 && n2 > 0 && n1 < 400, 1'b1);
    idle();
    $display("inverse done");
  endtask : t_inverse

  // Level itself picks up in neither direction
  task t_under();
    wr(4'h2, 32'h1);
    setm(16'h64, 1'b0);
    pc(2);
    wr(4'h0, 32'h10);
    pc(3);
    chk("under_idle", pickup, 1'b0);
    setm(16'h50, 1'b0);
    pc(3);
    chk("under_pick", {pickup, start}, 2'h3);
    setm(16'h67, 1'b0);
    pc(3);
    chk("under_hold", pickup, 1'b1);
    setm(16'h68, 1'b0);
    pc(3);
    chk("under_drop", {pickup, start, trip}, 3'h0);
    setm(16'h64, 1'b0);
    pc(2);
    wr(4'h0, 32'h0);
    idle();
    $display("under done");
  endtask : t_under

  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_definite();
    t_instant();
    t_early();
    t_block();
    t_inverse();
    t_under();
    report_and_stop();
  end

  // Whole run needs a few hundred clocks
  initial
  begin
    #1000000;
    fails++;
    report_and_stop();
  end

endmodule : protection_pickup_trip_timer_tb_top

bind protection_pickup_trip_timer trip_timer_monitor #(.CYCLE_CLOCKS(CYCLE_CLOCKS))
  i_trip_timer_monitor (
  .clock(clock), .rst(rst), .read_strobe(read_strobe), .read_data(read_data),
  .start(start), .trip(trip), .blocked(blocked), .pickup(pickup),
  .display_event(display_event), .block_event_valid(block_event_valid));

`default_nettype wire
